// ---- design/buck_fault_supervisor.sv ----
/*
  Fault and sequencing supervisor of a synchronous buck converter, with an
  AHB-Lite register slave. Assumes comparator flags synchronous to hclk.
*/
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "buck_fault_supervisor_consts.svh"

module buck_fault_supervisor #(
  parameter int PG_DELAY_CYC = `CYC(`PG_DELAY_NS),
  parameter int SS_CYC       = `CYC(`SS_TIME_NS),
  parameter int UV_CYC       = `CYC(`UV_DELAY_NS),
  parameter int PGF_CYC      = `CYC(`FAULT_DELAY_NS)
) (
  // Clock and reset
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  // AHB-Lite slave
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  // Supervisory inputs
  input  wire logic                               enable_in,
  input  wire logic                               bias_ok,
  input  wire logic                               input_ok,
  input  wire logic                               over_temp,
  input  wire logic                               mode_strap_high,
  input  wire buck_fault_supervisor_pkg::sense_s  sense,
  // Outputs
  output buck_fault_supervisor_pkg::drive_s       drive,
  output logic                                    power_ok_out,
  output logic                                    softstart_discharge
);
  import buck_fault_supervisor_pkg::*;

  initial
  begin
    if (PG_DELAY_CYC < 1 || SS_CYC < 1 || UV_CYC < 1 || PGF_CYC < 1 ||
        PG_DELAY_CYC > 2**20 || SS_CYC > 2**20)
      $error("buck_fault_supervisor: bad timing parameter");
  end

  function automatic logic [19:0] count_up(input logic [19:0] v);
    count_up = v + 20'h00001;
  endfunction

  sup_state_e  state_ff;
  sup_state_e  nxt_state;
  logic [19:0] ss_cnt_ff;
  logic [19:0] pg_cnt_ff;
  logic [19:0] uv_cnt_ff;
  logic [19:0] pgf_cnt_ff;
  logic        ss_int_done_ff;
  logic        pg_latched_ff;
  logic        en_prev_ff;
  logic        hs_pulse_ff;
  logic [3:0]  ctrl_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  addr_ff;
  logic        halt;
  logic        en_rise;
  logic        uv_expired;
  logic        auto_skip;

  assign en_rise    = enable_in && !en_prev_ff;
  assign halt       = !enable_in || over_temp || !input_ok;  // RL17
  assign uv_expired = (uv_cnt_ff == 20'(UV_CYC - 1)) && sense.fb_under;
  // Register override selects forced continuous even with strap high
  assign auto_skip  = mode_strap_high && !ctrl_ff[`CTRL_OVR_BIT];  // RL21 RL22

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_prev_ff <= 1'b0;
    else
      en_prev_ff <= enable_in;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF:
        if (!halt)
          nxt_state = ST_SOFT;
      ST_SOFT:
        if (halt)
          nxt_state = ST_DISCH;  // RL19 RL20
        else if (ss_int_done_ff && sense.fb_ss_done)
          nxt_state = ST_RUN;  // RL4
      ST_RUN:
        if (halt)
          nxt_state = ST_DISCH;
        else if (sense.fb_over)
          nxt_state = ST_OVER;  // RL10
        else if (uv_expired)
          nxt_state = ST_LATCHED;  // RL8
      ST_OVER:
        if (halt)
          nxt_state = ST_DISCH;
        else if (uv_expired)
          nxt_state = ST_LATCHED;  // RL11
      ST_LATCHED:
        // Heat alone must not clear a latched fault; input loss does
        if (!enable_in || !input_ok)
          nxt_state = ST_DISCH;  // RL12 RL19
      ST_DISCH:
        if (sense.fb_discharged && !halt)
          nxt_state = ST_OFF;  // RL16
      default:
        nxt_state = ST_OFF;
    endcase
  end

  // Bias lockout clears every latch and counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= ST_OFF;
    else if (!bias_ok)
      state_ff <= ST_OFF;  // RL18 RL23
    else
      state_ff <= nxt_state;
  end

  // Internal soft-start ramp timer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ss_cnt_ff      <= 20'h00000;
      ss_int_done_ff <= 1'b0;
    end
    else if (state_ff != ST_SOFT)
    begin
      ss_cnt_ff      <= 20'h00000;
      ss_int_done_ff <= (state_ff == ST_RUN) || (state_ff == ST_OVER);
    end
    else if (ss_cnt_ff == 20'(SS_CYC - 1))
      ss_int_done_ff <= 1'b1;  // RL3
    else
      ss_cnt_ff <= count_up(ss_cnt_ff);  // RL23
  end

  // Undervoltage delay; idle until soft-start ends
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      uv_cnt_ff <= 20'h00000;
    else if ((state_ff != ST_RUN && state_ff != ST_OVER) || !sense.fb_under)
      uv_cnt_ff <= 20'h00000;  // RL9 RL13
    else if (!uv_expired)
      uv_cnt_ff <= count_up(uv_cnt_ff);  // RL8
  end

  // Power-ok qualification delay after soft-start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pg_cnt_ff <= 20'h00000;
    else if (state_ff != ST_RUN)
      pg_cnt_ff <= 20'h00000;
    else if (pg_cnt_ff != 20'(PG_DELAY_CYC))
      pg_cnt_ff <= count_up(pg_cnt_ff);  // RL2
  end

  // Window fault filter for power ok
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pgf_cnt_ff <= 20'h00000;
    else if (state_ff != ST_RUN || !(sense.fb_under || sense.fb_over))
      pgf_cnt_ff <= 20'h00000;
    else if (pgf_cnt_ff != 20'(PGF_CYC))
      pgf_cnt_ff <= count_up(pgf_cnt_ff);  // RL5
  end

  // Power-ok latch; cleared by enable edge or bias loss
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pg_latched_ff <= 1'b0;
    else if (!bias_ok || en_rise)
      pg_latched_ff <= 1'b0;  // RL6
    else if (pgf_cnt_ff == 20'(PGF_CYC) || state_ff == ST_OVER || state_ff == ST_LATCHED)
      pg_latched_ff <= 1'b1;  // RL5
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_ok_out <= 1'b0;
    else
      power_ok_out <= (state_ff == ST_RUN) && (pg_cnt_ff == 20'(PG_DELAY_CYC)) &&
                      !pg_latched_ff && bias_ok;  // RL7
  end

  // High-side on-time pulse after negative limit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hs_pulse_ff <= 1'b0;
    else if (state_ff != ST_RUN && state_ff != ST_OVER)
      hs_pulse_ff <= 1'b0;
    else if (sense.neg_limit && !hs_pulse_ff)
      hs_pulse_ff <= 1'b1;  // RL1
    else if (sense.on_time_done)
      hs_pulse_ff <= 1'b0;  // RL1
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drive               <= '0;
      softstart_discharge <= 1'b1;
    end
    else
    begin
      softstart_discharge <= (state_ff == ST_OFF) || (state_ff == ST_DISCH);  // RL19 RL20
      drive.discharge_on  <= (state_ff == ST_DISCH) && !sense.fb_discharged;  // RL16
      drive.neg_limit_en  <= (state_ff == ST_RUN) || (state_ff == ST_OVER) ||
                             (state_ff == ST_SOFT);  // RL15
      // Out-of-bounds only changes conduction mode, never the state
      drive.forced_continuous <= sense.fb_oob || !auto_skip || state_ff == ST_OVER;  // RL14 RL15
      case (state_ff)
        ST_SOFT, ST_RUN:
        begin
          drive.hs_on <= hs_pulse_ff;
          drive.ls_on <= !hs_pulse_ff && !(auto_skip && !sense.fb_oob && sense.zero_cross);
        end
        ST_OVER:
        begin
          drive.hs_on <= hs_pulse_ff;  // RL10 RL11
          drive.ls_on <= !hs_pulse_ff && !sense.neg_limit;  // RL1 RL10
        end
        default:
        begin
          drive.hs_on <= 1'b0;
          drive.ls_on <= 1'b0;
        end
      endcase
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      rd_pend_ff <= hsel && htrans[1] && !hwrite;
      addr_ff    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_ff <= `CTRL_RESET;
    else if (wr_pend_ff && addr_ff == `REG_CTRL)
      ctrl_ff <= hwdata[3:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      if (haddr[7:0] == `REG_CTRL)
        hrdata <= {28'h0000000, ctrl_ff};
      else if (haddr[7:0] == `REG_STATUS)
        hrdata <= {24'h000000, pg_latched_ff, power_ok_out, auto_skip,
                   ss_int_done_ff, 1'b0, state_ff};
      else
        hrdata <= 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// ---- design/buck_fault_supervisor_consts.svh ----
/*
  Timing constants and register map for the buck fault supervisor.
  Assumes a 50 MHz hclk and an AHB-Lite master.
*/
// Overview of operation
// (RL1) Negative limit: low-side off, one on-time, low-side on
// (RL2) Power ok rises 1.06 ms after soft-start
// (RL3) Internal soft-start ramp lasts 2 ms
// (RL4) External soft-start done at reference minus margin
// (RL5) Feedback out of window latches power ok low
// (RL6) Power ok latch clears on enable toggle
// (RL7) Power ok low by default until soft-start done
// (RL8) Undervoltage for 68 us latches both drivers off
// (RL9) Undervoltage protection disabled during soft-start
// (RL10) Overvoltage: high-side latched off, low-side on
// (RL11) Overvoltage cycles until undervoltage held, then latch
// (RL12) Faults clear only by supply or enable
// (RL13) Recovery above undervoltage restarts delay from zero
// (RL14) Out of bounds sets no fault, no latch
// (RL15) Out of bounds forces continuous conduction
// (RL16) Discharge holds FETs off until feedback low
// (RL17) Discharge entered on enable, heat, supply lockouts
// (RL18) Bias lockout shuts off without latching
// (RL19) Input lockout stops switching, reruns soft-start
// (RL20) Over-temperature stops, resumes with fresh soft-start
// (RL21) Mode strap high selects auto-skip
// (RL22) Mode strap low selects forced continuous
// (RL23) Timebase counters; bias lockout clears all
`ifndef BUCK_FAULT_SUPERVISOR_CONSTS_SVH
`define BUCK_FAULT_SUPERVISOR_CONSTS_SVH

`define CLK_MHZ        50
`define PG_DELAY_NS    1060000
`define SS_TIME_NS     2000000
`define FAULT_DELAY_NS 2000
`define UV_DELAY_NS    68000
`define CYC(ns)        (((ns) * `CLK_MHZ + 999) / 1000)

`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define CTRL_RESET     4'h0
`define CTRL_MODE_BIT  0
`define CTRL_OVR_BIT   1

`endif

// ---- design/buck_fault_supervisor_pkg.sv ----
/*
  Types for the buck fault supervisor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package buck_fault_supervisor_pkg;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b010,
    ST_OVER    = 3'b011,
    ST_LATCHED = 3'b100,
    ST_DISCH   = 3'b101
  } sup_state_e;

  typedef struct packed {
    logic fb_under;
    logic fb_over;
    logic fb_oob;
    logic fb_ss_done;
    logic fb_discharged;
    logic neg_limit;
    logic zero_cross;
    logic on_time_done;
  } sense_s;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic discharge_on;
    logic forced_continuous;
    logic neg_limit_en;
  } drive_s;

endpackage

// ---- dv/buck_fault_supervisor_chk.sv ----
/*
  Port checker for the buck fault supervisor.
  Assumes the bound instance is the top module, one hclk domain.
*/
module buck_fault_supervisor_chk
  import buck_fault_supervisor_pkg::*;
#(
  parameter int PGF_CYC = 100,
  parameter int UV_CYC  = 3400
) (
  // Clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // Observed
  input wire logic   hreadyout,
  input wire logic   hresp,
  input wire logic   bias_ok,
  input wire logic   input_ok,
  input wire logic   mode_strap_high,
  input wire sense_s sense,
  input wire drive_s drive,
  input wire logic   power_ok_out,
  input wire logic   softstart_discharge
);
  localparam int PGF_LIM = PGF_CYC + 4;
  localparam int UV_LIM  = UV_CYC + 4;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_bias_clears_pok: assert property (!bias_ok ##1 !bias_ok |=> !power_ok_out)
    else $error("power ok high without bias");
  a_disch_fets_off: assert property (drive.discharge_on |-> !drive.hs_on && !drive.ls_on)
    else $error("power fet on during discharge");
  a_pok_window_trip: assert property (power_ok_out && (sense.fb_under || sense.fb_over)
    |-> ##[1:PGF_LIM] (!power_ok_out || !(sense.fb_under || sense.fb_over)))
    else $error("power ok not dropped on window fault");
  a_uv_latch_off: assert property (power_ok_out && sense.fb_under
    |-> ##[1:UV_LIM] ((!drive.hs_on && !drive.ls_on) || !sense.fb_under))
    else $error("drivers not latched off on undervoltage");
  a_oob_forces_ccm: assert property (power_ok_out && sense.fb_oob ##1 sense.fb_oob
    |=> drive.forced_continuous && drive.neg_limit_en)
    else $error("out of bounds without forced continuous");
  a_strap_low_ccm: assert property (power_ok_out && !mode_strap_high ##1 !mode_strap_high
    |=> drive.forced_continuous)
    else $error("low strap not in forced continuous");
  a_input_loss_ss: assert property (bias_ok && !input_ok ##1 !input_ok
    |=> softstart_discharge)
    else $error("soft-start node not discharged on input loss");
endmodule

bind buck_fault_supervisor buck_fault_supervisor_chk #(.PGF_CYC(PGF_CYC), .UV_CYC(UV_CYC)) chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .bias_ok(bias_ok),
  .input_ok(input_ok), .mode_strap_high(mode_strap_high), .sense(sense), .drive(drive),
  .power_ok_out(power_ok_out), .softstart_discharge(softstart_discharge));

// ---- dv/tb.sv ----
/*
  Directed bench of the buck fault supervisor with short counts.
  Assumes a zero-wait AHB-Lite slave and comparator flags as levels.
*/
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import buck_fault_supervisor_pkg::*;
  localparam int PGD = 20, SSC = 40, UVC = 10, PGF = 3;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enable_in = 0, bias_ok = 1;
  logic input_ok = 1, over_temp = 0, mode_strap_high = 1, power_ok_out, softstart_discharge;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp;
  sense_s sense = '0;
  drive_s drive;
  int fails = 0, total_checks = 0, cyc = 0, n;
  always #10 hclk = ~hclk;
  buck_fault_supervisor #(.PG_DELAY_CYC(PGD), .SS_CYC(SSC), .UV_CYC(UVC), .PGF_CYC(PGF)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enable_in(enable_in), .bias_ok(bias_ok),
    .input_ok(input_ok), .over_temp(over_temp), .mode_strap_high(mode_strap_high),
    .sense(sense), .drive(drive), .power_ok_out(power_ok_out),
    .softstart_discharge(softstart_discharge));
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk_state(input sup_state_e s);
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(rd[2:0], s)
  endtask
  task automatic power_up();
    sense.fb_ss_done <= 1'b0; enable_in <= 1'b1;
    repeat (2) @(posedge hclk);
    sense.fb_discharged <= 1'b0;
    repeat (SSC + 8) @(posedge hclk);
    `CHK(power_ok_out, 1'b0)
    chk_state(ST_SOFT);
    sense.fb_ss_done <= 1'b1; n = 0;
    while (power_ok_out !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
    `CHK(n >= PGD && n <= PGD + 10, 1'b1)
  endtask
  task automatic halt(input int cause);
    case (cause)
      0: enable_in <= 1'b0;
      1: over_temp <= 1'b1;
      default: input_ok <= 1'b0;
    endcase
    repeat (4) @(posedge hclk);
    `CHK({drive.discharge_on, drive.hs_on, drive.ls_on, power_ok_out}, 4'h8)
    `CHK(softstart_discharge, 1'b1)
    sense.fb_discharged <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(drive.discharge_on, 1'b0)
    enable_in <= 1'b0; over_temp <= 1'b0; input_ok <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic t_regs();
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 32'h0, 32'hffffffff);
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'hf)
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_modes();
    power_up();
    mode_strap_high <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHK(drive.forced_continuous, 1'b1)
    mode_strap_high <= 1'b1; sense.fb_oob <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK({drive.forced_continuous, drive.neg_limit_en, power_ok_out}, 3'h7)
    sense.fb_oob <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHK(drive.forced_continuous, 1'b0)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK({rd[5], rd[2:0]}, {1'b1, ST_RUN})
  endtask
  task automatic t_pok_uv();
    sense.fb_under <= 1'b1;
    repeat (UVC - 3) @(posedge hclk);
    sense.fb_under <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(power_ok_out, 1'b0)
    sense.fb_under <= 1'b1;
    repeat (UVC - 3) @(posedge hclk);
    sense.fb_under <= 1'b0;
    chk_state(ST_RUN);
    repeat (20) @(posedge hclk);
    `CHK(power_ok_out, 1'b0)
    sense.fb_under <= 1'b1;
    repeat (UVC + 5) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on}, 2'h0)
    chk_state(ST_LATCHED);
    sense.fb_under <= 1'b0;
    halt(0);
    power_up();
  endtask
  task automatic t_over();
    sense.fb_over <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on}, 2'h1)
    chk_state(ST_OVER);
    sense.neg_limit <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on}, 2'h2)
    sense.neg_limit <= 1'b0; sense.on_time_done <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on}, 2'h1)
    sense.on_time_done <= 1'b0; sense.fb_over <= 1'b0; sense.fb_under <= 1'b1;
    repeat (UVC + 5) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on}, 2'h0)
    chk_state(ST_LATCHED);
    sense.fb_under <= 1'b0;
    halt(0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({drive, power_ok_out, softstart_discharge}, 7'h01)
    t_regs();
    t_modes();
    t_pok_uv();
    t_over();
    for (int c = 1; c < 3; c++)
    begin
      power_up();
      halt(c);
    end
    power_up();
    bias_ok <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHK({drive.hs_on, drive.ls_on, power_ok_out}, 3'h0)
    bias_ok <= 1'b1; enable_in <= 1'b0;
    @(posedge hclk);
    power_up();
    print_verdict();
  end
endmodule
